// file: core/lpss_pkg.sv
// Package for the LED panel serial streamer: register map, fields, types.
// Assumes a single 10 MHz system clock and a plain strobe register port.
`default_nettype none
package lpss_pkg;
	localparam logic [31:0] LPSS_ADDR_MODE   = 32'h40006400;
	localparam logic [31:0] LPSS_ADDR_DIV    = 32'h40006401;
	localparam logic [31:0] LPSS_ADDR_STATUS = 32'h40006404;
	localparam logic [31:0] LPSS_ADDR_FIFO   = 32'h40006408;
	localparam logic [31:0] LPSS_ADDR_DCNT   = 32'h40006410;
	localparam logic [31:0] LPSS_ADDR_DMAIN  = 32'h40006414;
	localparam logic [31:0] LPSS_ADDR_DAUX   = 32'h40006418;

	localparam logic [7:0]  LPSS_MODE_RST = 8'h02;
	localparam logic [7:0]  LPSS_DIV_RST  = 8'h10;
	localparam logic [15:0] LPSS_DCNT_RST = 16'h0000;
	localparam logic [15:0] LPSS_ADDR_RST = 16'h0000;

	localparam int LPSS_B_LSB_FIRST = 0;
	localparam int LPSS_B_CLEAR     = 1;
	localparam int LPSS_B_INVERT    = 2;
	localparam int LPSS_B_OUT_EN    = 3;
	localparam int LPSS_B_DMA_EN    = 4;
	localparam int LPSS_B_FIFO_IE   = 5;
	localparam int LPSS_B_LANE_LO   = 6;
	localparam int LPSS_B_ST_COUNT  = 0;
	localparam int LPSS_B_ST_CLK    = 4;
	localparam int LPSS_B_ST_LOW    = 5;
	localparam int LPSS_B_ST_EMPTY  = 6;
	localparam int LPSS_B_ST_DONE   = 7;

	localparam logic [2:0] LPSS_LOW_LEVEL = 3'h2;
	localparam logic [2:0] LPSS_FIFO_BYTES = 3'h2;
	localparam int         LPSS_CNT_BITS  = 12;
	localparam logic [15:0] LPSS_ADDR_STEP = 16'h0002;

	typedef enum logic [1:0] {
		LPSS_LANE_ONE,
		LPSS_LANE_TWO,
		LPSS_LANE_FOUR,
		LPSS_LANE_FOUR_AUX
	} lpss_lane_t;

	typedef enum logic [1:0] {
		LPSS_DMA_IDLE,
		LPSS_DMA_MAIN,
		LPSS_DMA_AUX
	} lpss_dma_t;

	typedef struct packed {
		logic        req;
		logic [15:0] addr;
	} lpss_mem_req_t;

	typedef struct packed {
		logic [7:0]  mode;
		logic [7:0]  div;
		logic        done_flag;
		logic        low_flag;
		logic [15:0] dcnt;
		logic [15:0] dmain;
		logic [15:0] daux;
		logic        fifo_full;
		logic [15:0] fifo_word;
		logic [15:0] aux_word;
		logic        aux_valid;
		lpss_dma_t   dma;
		logic        mem_req;
		logic [15:0] mem_addr;
		logic        busy;
		logic [15:0] sh_main;
		logic [15:0] sh_aux;
		logic [4:0]  bits_left;
		logic [7:0]  div_cnt;
		logic        sclk;
		logic [3:0]  lanes;
		logic [31:0] rdata;
	} lpss_state_t;
endpackage : lpss_pkg
`default_nettype wire

// file: core/lpss_streamer.sv
// LED panel serial streamer: register slave, one-entry halfword FIFO,
// DMA fetch engine and 1/2/4-lane shifter with a divided shift clock.
// Assumes a memory port that answers a fetch with mem_valid_i later.
`default_nettype none
// Functional notes
// - Lane mode bits 7:6: 00 lane0, 01 lanes 0-1, 10 lanes 0-3.
// - Mode 11 drives four lanes, lanes 2-3 fed from auxiliary buffer.
// - Bit 5 enables interrupt when FIFO drains from two bytes to none.
// - Bit 4 enables DMA fetch and DMA completion interrupt together.
// - Bit 3 gates shift clock and lane outputs.
// - Bit 2 inverts every serial data bit.
// - Bit 1 forces FIFO empty, clears counters and flags; resets to one.
// - Bit 0 high sends LSB first, low sends MSB first.
// - Shift clock equals system clock over 8-bit divider, reset 0x10.
// - DMA done flag sets at finish; clears by write-one or count write.
// - Status bit 6 reads one while FIFO empty.
// - Low flag sets when count drops from two to zero; clears by write-one or FIFO write.
// - Status bit 4 shows present shift clock level.
// - Status bits 2:0 give FIFO byte count, always even.
// - FIFO port takes one 16-bit halfword per write.
// - DMA count holds main words left, 12 bits, decrements per fetch.
// - Main address preset by software, steps by two per fetch.
// - Aux address preset by software, steps by two per fetch.
module lpss_streamer
	import lpss_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rstn_i,
	input  wire logic [31:0] addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             irq_o,
	output logic             mem_req_o,
	output logic      [15:0] mem_addr_o,
	input  wire logic        mem_valid_i,
	input  wire logic [15:0] mem_data_i,
	output logic             shift_clock_out_o,
	output logic             shift_clock_oe_o,
	output logic      [3:0]  data_lane_o,
	output logic      [3:0]  data_lane_oe_o
);
	lpss_state_t q;
	lpss_state_t d;

	logic       clr;
	logic       wr_mode;
	logic       wr_div;
	logic       wr_stat;
	logic       wr_fifo;
	logic       wr_dcnt;
	logic       wr_dmain;
	logic       wr_daux;
	logic       lsb_first;
	logic       fetch_aux;
	logic [2:0] byte_count;
	logic [1:0] lane_mode;
	logic       load;
	logic       fall;
	logic [7:0] div_eff;
	logic [4:0] width;
	logic [3:0] bit_vec;
	logic       pull;
	logic [7:0] status;

	assign clr       = q.mode[LPSS_B_CLEAR];
	assign lsb_first = q.mode[LPSS_B_LSB_FIRST];
	assign lane_mode = q.mode[LPSS_B_LANE_LO +: 2];
	assign fetch_aux = (lane_mode == LPSS_LANE_FOUR_AUX);
	assign wr_mode   = wr_i && addr_i == LPSS_ADDR_MODE;
	assign wr_div    = wr_i && addr_i == LPSS_ADDR_DIV;
	assign wr_stat   = wr_i && addr_i == LPSS_ADDR_STATUS;
	assign wr_fifo   = wr_i && addr_i == LPSS_ADDR_FIFO;
	assign wr_dcnt   = wr_i && addr_i == LPSS_ADDR_DCNT;
	assign wr_dmain  = wr_i && addr_i == LPSS_ADDR_DMAIN;
	assign wr_daux   = wr_i && addr_i == LPSS_ADDR_DAUX;
	// Divider of zero behaves as one
	assign div_eff   = (q.div == 8'h00) ? 8'h01 : q.div;
	// Two bytes per held halfword
	assign byte_count = q.fifo_full ? LPSS_FIFO_BYTES : 3'h0;

	// Bits per word and lane
	always_comb
	begin
		unique case (lane_mode)
			LPSS_LANE_ONE: width = 5'h10;
			LPSS_LANE_TWO: width = 5'h08;
			LPSS_LANE_FOUR: width = 5'h04;
			// Main word on lanes 0-1, aux word on lanes 2-3
			LPSS_LANE_FOUR_AUX: width = 5'h08;
		endcase
	end

	assign status = {q.done_flag, ~q.fifo_full, q.low_flag, q.sclk, 1'b0, byte_count};

	always_comb
	begin
		d    = q;
		load = 1'b0;
		fall = 1'b0;
		pull = 1'b0;
		bit_vec = 4'h0;
		d.rdata = 32'h0;

		// Register reads, answered next cycle
		if (rd_i)
		begin
			unique case (addr_i)
				LPSS_ADDR_MODE:   d.rdata = {24'h0, q.mode};
				LPSS_ADDR_DIV:    d.rdata = {24'h0, q.div};
				LPSS_ADDR_STATUS: d.rdata = {24'h0, status};
				LPSS_ADDR_DCNT:   d.rdata = {16'h0, q.dcnt};
				LPSS_ADDR_DMAIN:  d.rdata = {16'h0, q.dmain};
				LPSS_ADDR_DAUX:   d.rdata = {16'h0, q.daux};
				default:          d.rdata = 32'h0;
			endcase
		end

		if (wr_mode)
			d.mode = wdata_i[7:0];
		if (wr_div)
			d.div = wdata_i[7:0];
		if (wr_dmain)
			d.dmain = wdata_i[15:0];
		if (wr_daux)
			d.daux = wdata_i[15:0];
		if (wr_dcnt)
			d.dcnt = {4'h0, wdata_i[LPSS_CNT_BITS-1:0]};

		// Shift clock divider: half period high, half low for even dividers
		if (q.busy)
		begin
			if (q.div_cnt + 8'h01 >= div_eff)
			begin
				d.div_cnt = 8'h00;
				fall = 1'b1;
			end
			else
				d.div_cnt = q.div_cnt + 8'h01;
			d.sclk = (q.div_cnt + 8'h01 >= div_eff) ? 1'b0
				: ((d.div_cnt >= (div_eff >> 1)) ? 1'b1 : 1'b0);
		end

		// Data moves only at the falling edge of the shift clock
		if (fall)
		begin
			if (q.bits_left > 5'h1)
			begin
				d.bits_left = q.bits_left - 5'h1;
				if (lsb_first)
				begin
					d.sh_main = q.sh_main >> 1;
					d.sh_aux  = q.sh_aux >> 1;
				end
				else
				begin
					d.sh_main = q.sh_main << 1;
					d.sh_aux  = q.sh_aux << 1;
				end
			end
			else
			begin
				d.busy = 1'b0;
				d.sclk = 1'b0;
				pull = 1'b1;
			end
		end

		// Start a new word when idle or at the end of the last one
		if ((!q.busy || pull) && q.fifo_full && (!fetch_aux || q.aux_valid))
		begin
			load = 1'b1;
			d.busy = 1'b1;
			d.fifo_full = 1'b0;
			d.aux_valid = 1'b0;
			d.sh_main = q.fifo_word;
			d.sh_aux = q.aux_word;
			d.bits_left = width;
			d.div_cnt = 8'h00;
			d.sclk = 1'b0;
		end

		// Lanes take the head bits of the current word
		if (load || (fall && q.bits_left > 5'h1))
		begin
			unique case (lane_mode)
				LPSS_LANE_ONE:
					bit_vec = {3'h0, lsb_first ? d.sh_main[0] : d.sh_main[15]};
				LPSS_LANE_TWO:
					bit_vec = lsb_first ? {2'h0, d.sh_main[8], d.sh_main[0]}
						: {2'h0, d.sh_main[7], d.sh_main[15]};
				LPSS_LANE_FOUR:
					bit_vec = lsb_first
						? {d.sh_main[12], d.sh_main[8], d.sh_main[4], d.sh_main[0]}
						: {d.sh_main[3], d.sh_main[7], d.sh_main[11], d.sh_main[15]};
				LPSS_LANE_FOUR_AUX:
					bit_vec = lsb_first
						? {d.sh_aux[8], d.sh_aux[0], d.sh_main[8], d.sh_main[0]}
						: {d.sh_aux[7], d.sh_aux[15], d.sh_main[7], d.sh_main[15]};
			endcase
			d.lanes = bit_vec ^ {4{q.mode[LPSS_B_INVERT]}};
		end

		// DMA fetch engine
		unique case (q.dma)
			LPSS_DMA_IDLE:
				if (q.mode[LPSS_B_DMA_EN] && q.dcnt != 16'h0 && !d.fifo_full)
				begin
					d.dma = fetch_aux ? LPSS_DMA_AUX : LPSS_DMA_MAIN;
					d.mem_req = 1'b1;
					d.mem_addr = fetch_aux ? q.daux : q.dmain;
				end
			LPSS_DMA_AUX:
				if (mem_valid_i)
				begin
					d.aux_word = mem_data_i;
					d.aux_valid = 1'b1;
					d.daux = q.daux + LPSS_ADDR_STEP;
					d.dma = LPSS_DMA_MAIN;
					d.mem_addr = q.dmain;
				end
			LPSS_DMA_MAIN:
				if (mem_valid_i)
				begin
					d.fifo_word = mem_data_i;
					d.fifo_full = 1'b1;
					d.dmain = q.dmain + LPSS_ADDR_STEP;
					d.dcnt = q.dcnt - 16'h1;
					d.mem_req = 1'b0;
					d.dma = LPSS_DMA_IDLE;
					if (q.dcnt == 16'h1)
						d.done_flag = 1'b1;
				end
			default:
				d.dma = LPSS_DMA_IDLE;
		endcase

		// Software halfword into the FIFO
		if (wr_fifo && !d.fifo_full)
		begin
			d.fifo_word = wdata_i[15:0];
			d.fifo_full = 1'b1;
			if (fetch_aux)
				d.aux_valid = 1'b1;
		end

		// Flag clears first so a same-cycle set wins
		if (wr_stat && wdata_i[LPSS_B_ST_DONE])
			d.done_flag = 1'b0;
		if (wr_dcnt)
			d.done_flag = 1'b0;
		if ((wr_stat && wdata_i[LPSS_B_ST_LOW]) || wr_fifo)
			d.low_flag = 1'b0;
		if (!d.fifo_full && q.fifo_full)
			d.low_flag = 1'b1;
		if (q.dma == LPSS_DMA_MAIN && mem_valid_i && q.dcnt == 16'h1)
			d.done_flag = 1'b1;

		// Held clear: FIFO, counters, flags and shifter
		if (clr)
		begin
			d.fifo_full = 1'b0;
			d.aux_valid = 1'b0;
			d.done_flag = 1'b0;
			d.low_flag = 1'b0;
			d.dcnt = LPSS_DCNT_RST;
			d.busy = 1'b0;
			d.bits_left = 5'h0;
			d.div_cnt = 8'h00;
			d.sclk = 1'b0;
			d.lanes = 4'h0;
			d.dma = LPSS_DMA_IDLE;
			d.mem_req = 1'b0;
		end
		if (wr_mode)
			d.mode = wdata_i[7:0];
	end

	always_ff @(posedge clk_i)
	begin
		if (!rstn_i)
		begin
			q <= '0;
			q.mode <= LPSS_MODE_RST;
			q.div <= LPSS_DIV_RST;
			q.dcnt <= LPSS_DCNT_RST;
			q.dmain <= LPSS_ADDR_RST;
			q.daux <= LPSS_ADDR_RST;
			q.dma <= LPSS_DMA_IDLE;
		end
		else
			q <= d;
	end

	assign rdata_o = q.rdata;
	// Interrupt: FIFO low gated by bit 5, DMA done by bit 4
	assign irq_o = (q.low_flag && q.mode[LPSS_B_FIFO_IE])
		|| (q.done_flag && q.mode[LPSS_B_DMA_EN]);
	assign mem_req_o = q.mem_req;
	assign mem_addr_o = q.mem_addr;
	assign shift_clock_out_o = q.sclk;
	assign shift_clock_oe_o = q.mode[LPSS_B_OUT_EN];
	assign data_lane_o = q.lanes;

	// Enabled lanes follow the lane mode
	always_comb
	begin
		if (!q.mode[LPSS_B_OUT_EN])
			data_lane_oe_o = 4'h0;
		else if (lane_mode == LPSS_LANE_ONE)
			data_lane_oe_o = 4'h1;
		else if (lane_mode == LPSS_LANE_TWO)
			data_lane_oe_o = 4'h3;
		else
			data_lane_oe_o = 4'hf;
	end
endmodule : lpss_streamer
`default_nettype wire

// file: test/lpss_assertions.sv
// Port checker for the LED panel serial streamer.
// Assumes one clock and a synchronous active-low reset.
`default_nettype none
module lpss_checker
	import lpss_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rstn_i,
	input wire logic [31:0] addr_i,
	input wire logic        wr_i,
	input wire logic        rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic        mem_req_o,
	input wire logic [15:0] mem_addr_o,
	input wire logic        mem_valid_i,
	input wire logic        shift_clock_out_o,
	input wire logic        shift_clock_oe_o,
	input wire logic [3:0]  data_lane_o,
	input wire logic [3:0]  data_lane_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_oe_gate: assert property (data_lane_oe_o[0] == shift_clock_oe_o)
		else $error("lane enable differs from clock enable");
	a_lane_set: assert property (shift_clock_oe_o |-> data_lane_oe_o inside {4'h1, 4'h3, 4'hf})
		else $error("lane enable pattern illegal");
	a_oe_hold: assert property (!$past(wr_i) |-> $stable(data_lane_oe_o))
		else $error("lane enables moved without a write");
	a_lane_hold: assert property ($rose(shift_clock_out_o) |-> $stable(data_lane_o))
		else $error("lanes moved at clock rise");
	a_lane_move: assert property ($changed(data_lane_o) |-> !shift_clock_out_o)
		else $error("lanes moved with clock high");
	a_rd_quiet: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data without a read");
	a_req_hold: assert property (mem_req_o && !mem_valid_i && !wr_i |=> mem_req_o && $stable(mem_addr_o))
		else $error("fetch dropped before answer");
	a_addr_step: assert property (mem_req_o && mem_valid_i |=> !mem_req_o || mem_addr_o != $past(mem_addr_o))
		else $error("fetch address not advanced");
	a_clk_level: assert property (rd_i && addr_i == LPSS_ADDR_STATUS |=> rdata_o[4] == $past(shift_clock_out_o))
		else $error("status clock level differs from shift clock");
endmodule : lpss_checker
bind lpss_streamer lpss_checker chk_u (.clk_i, .rstn_i, .addr_i, .wr_i, .rd_i, .rdata_o, .mem_req_o,
	.mem_addr_o, .mem_valid_i, .shift_clock_out_o, .shift_clock_oe_o, .data_lane_o, .data_lane_oe_o);
`default_nettype wire

// file: test/lpss_panel_model.sv
// Panel shift chain: takes one bit per lane on each shift clock rise.
// Assumes the system clock is much faster than the shift clock.
`default_nettype none
module lpss_panel_model
(
	input  wire logic             clk_i,
	input  wire logic             sclk_i,
	input  wire logic [3:0]       lane_i,
	output logic      [3:0][15:0] sr_o    = '0,
	output logic      [15:0]      rises_o = 16'h0,
	output logic      [7:0]       per_o   = 8'h0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       prev = 1'b0;
	logic [7:0] gap  = 8'h0;
	always @(posedge clk_i)
	begin
		prev <= sclk_i;
		gap  <= (sclk_i && !prev) ? 8'h1 : gap + 8'h1;
		if (sclk_i && !prev)
		begin
			for (int k = 0; k < 4; k++)
				sr_o[k] <= {sr_o[k][14:0], lane_i[k]};
			rises_o <= rises_o + 16'h1;
			per_o   <= gap;
		end
	end
endmodule : lpss_panel_model
`default_nettype wire

// file: test/test_lpss_streamer.sv
// Bench for the LED streamer: register tasks, memory responder, panel.
// Assumes the port checker is bound from its own file.
`default_nettype none
module test_lpss_streamer
	import lpss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic             clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, mv = 1'b0;
	logic [31:0]      addr = 32'h0, wdata = 32'h0, rdata;
	logic [15:0]      md = 16'h0, maddr, rises;
	logic [3:0]       lanes, loe;
	logic [3:0][15:0] sr;
	logic [7:0]       per;
	logic             irq, mreq, sclk, soe;
	logic [1:0]       lat = 2'h0;
	logic [15:0]      alog [$];
	logic [7:0]       cfg [5] = '{8'h28, 8'h29, 8'h2c, 8'h68, 8'had};
	int               mismatches = 0, checks = 0, bw;
	lpss_streamer dut_u (.clk_i(clk), .rstn_i(rstn), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq), .mem_req_o(mreq),
		.mem_addr_o(maddr), .mem_valid_i(mv), .mem_data_i(md), .shift_clock_out_o(sclk),
		.shift_clock_oe_o(soe), .data_lane_o(lanes), .data_lane_oe_o(loe));
	lpss_panel_model panel_u (.clk_i(clk), .sclk_i(sclk), .lane_i(lanes), .sr_o(sr),
		.rises_o(rises), .per_o(per));
	initial forever #50 clk = ~clk;
	// Memory answers a fetch two cycles after first seeing it
	always @(posedge clk)
	begin
		lat <= (mreq && !mv) ? lat + 2'h1 : 2'h0;
		mv  <= mreq && !mv && lat == 2'h2;
		md  <= maddr ^ 16'h3c00;
		if (mreq && !mv && lat == 2'h2)
			alog.push_back(maddr);
	end
	task end_of_test;
		if (mismatches == 0 && checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask : chk
	task wr_r(input logic [31:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		@(posedge clk);
	endtask : wr_r
	task rd_r(input string n, input logic [31:0] a, input logic [31:0] exp);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#10 chk(n, rdata, exp);
		@(posedge clk);
	endtask : rd_r
	task wait_rises(input int n);
		logic [15:0] r0;
		r0 = rises;
		for (int i = 0; i < 2000 && rises !== r0 + 16'(n); i++)
			@(posedge clk);
		chk("rises", 32'(rises), 32'(r0 + 16'(n)));
		// One bit period to finish the last bit
		repeat (4) @(posedge clk);
	endtask : wait_rises
	function logic [31:0] msk(input logic [15:0] x, input int w, input int sh);
		return 32'((x >> sh) & ((16'h1 << w) - 16'h1));
	endfunction : msk
	function logic [15:0] order(input logic [15:0] w, input logic [7:0] m);
		logic [15:0] v;
		for (int i = 0; i < 16; i++)
			v[i] = m[0] ? w[15 - i] : w[i];
		return m[2] ? ~v : v;
	endfunction : order
	initial
	begin
		#1000000;
		mismatches++;
		end_of_test;
	end
	initial
	begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		rd_r("mode", LPSS_ADDR_MODE, 32'h02);
		rd_r("div", LPSS_ADDR_DIV, 32'h10);
		rd_r("status", LPSS_ADDR_STATUS, 32'h40);
		rd_r("count", LPSS_ADDR_DCNT, 32'h0);
		rd_r("unmapped", 32'h40006402, 32'h0);
		chk("oe", 32'(loe), 32'h0);
		chk("soe", 32'(soe), 32'h0);
		wr_r(LPSS_ADDR_DIV, 32'h4);
		for (int c = 0; c < 5; c++)
		begin
			wr_r(LPSS_ADDR_MODE, 32'(cfg[c]));
			wr_r(LPSS_ADDR_FIFO, 32'hb38d);
			bw = 16 >> cfg[c][7:6];
			wait_rises(bw);
			for (int k = 0; k < 16 / bw; k++)
				chk("lane", msk(sr[k], bw, 0), msk(order(16'hb38d, cfg[c]), bw, 16 - bw * (k + 1)));
			chk("oe", 32'(loe), (32'h1 << (16 / bw)) - 32'h1);
			chk("soe", 32'(soe), 32'h1);
		end
		chk("period", 32'(per), 32'h4);
		rd_r("status", LPSS_ADDR_STATUS, 32'h60);
		chk("irq", 32'(irq), 32'h1);
		wr_r(LPSS_ADDR_STATUS, 32'h20);
		rd_r("status", LPSS_ADDR_STATUS, 32'h40);
		chk("irq", 32'(irq), 32'h0);
		wr_r(LPSS_ADDR_DMAIN, 32'h0100);
		wr_r(LPSS_ADDR_MODE, 32'h58);
		wr_r(LPSS_ADDR_DCNT, 32'h2);
		wait_rises(16);
		rd_r("count", LPSS_ADDR_DCNT, 32'h0);
		rd_r("main", LPSS_ADDR_DMAIN, 32'h0104);
		rd_r("status", LPSS_ADDR_STATUS, 32'he0);
		chk("irq", 32'(irq), 32'h1);
		chk("lane", msk(sr[0], 8, 0), 32'h3d);
		chk("lane", msk(sr[1], 8, 0), 32'h02);
		wr_r(LPSS_ADDR_DCNT, 32'h0);
		rd_r("status", LPSS_ADDR_STATUS, 32'h60);
		wr_r(LPSS_ADDR_DAUX, 32'h0200);
		wr_r(LPSS_ADDR_DMAIN, 32'h0300);
		wr_r(LPSS_ADDR_MODE, 32'hd8);
		wr_r(LPSS_ADDR_DCNT, 32'h1);
		wait_rises(8);
		chk("lane", msk(sr[0], 8, 0), 32'h3f);
		chk("lane", msk(sr[2], 8, 0), 32'h3e);
		chk("lane", msk(sr[3], 8, 0), 32'h00);
		chk("fetch", 32'(alog[alog.size() - 2]), 32'h0200);
		chk("fetch", 32'(alog[$]), 32'h0300);
		rd_r("aux", LPSS_ADDR_DAUX, 32'h0202);
		wr_r(LPSS_ADDR_MODE, 32'h08);
		wr_r(LPSS_ADDR_DCNT, 32'h3);
		repeat (20) @(posedge clk);
		chk("req", 32'(mreq), 32'h0);
		rd_r("count", LPSS_ADDR_DCNT, 32'h3);
		wr_r(LPSS_ADDR_MODE, 32'h0a);
		rd_r("count", LPSS_ADDR_DCNT, 32'h0);
		rd_r("status", LPSS_ADDR_STATUS, 32'h40);
		end_of_test;
	end
endmodule : test_lpss_streamer
`default_nettype wire
